// ==== rtl/sbstap_top.sv ====
`timescale 1ns/1ps
`include "sbstap_cfg.svh"
// Contract
// - Inputs sampled on rising test clock, outputs change on falling edge.
// - Mode select steps the controller each rising edge; open reads high.
// - Data enters at register MSB, leaves from LSB.
// - Exactly one scan register sits on the path, chosen by instruction.
// - Data-out driven only in shift states, otherwise high impedance.
// - Five rising edges with mode select high reset the controller.
// - Test port reset never disturbs memory operation.
// - Power-up resets the test port so data-out starts off.
// - Three-bit instruction register loads IDCODE at reset.
// - Capture-IR loads binary 01 into the two low bits.
// - Single-bit bypass stage, cleared when BYPASS executes.
// - Boundary register captures ring in Capture-DR, shifts in Shift-DR.
// - EXTEST, SAMPLE/PRELOAD and SAMPLE Z capture the ring.
// - IDCODE captures a fixed 32-bit code and shifts it out.
// - Instruction shifts in Shift-IR, takes effect at Update-IR.
// - Stopped test clock freezes the port in its last state; srst reaches it only on test clock edges.
// - Controller states and transitions follow the standard machine.
// - SAMPLE Z forces all memory data outputs off.
// - Output-enable cell steers data bus under EXTEST, preset high.
module sbstap_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire sbstap_pkg::sbstap_ring_t ring_in,
   output sbstap_pkg::sbstap_ring_t ring_drive,
   output logic extest_active,
   output logic q_bus_hiz
);

   // ===============================================================
   // Test clock domain
   sbstap_pkg::sbstap_tck_t t_r;
   sbstap_pkg::sbstap_tck_t t_nxt;
   sbstap_pkg::sbstap_out_t o_r;
   sbstap_pkg::sbstap_out_t o_nxt;
   logic ring_cap;
   logic [`SBSTAP_ID_W-1:0] id_val;

   assign id_val = `SBSTAP_IDCODE_VAL;

   always_comb begin
      ring_cap = 1'b0;
      t_nxt = t_r;
      // Power-up reset carried over from the core reset
      t_nxt.rst_meta = srst;
      t_nxt.rst_sync = t_r.rst_meta;
      t_nxt.ring_meta = ring_in;
      t_nxt.ring_sync = t_r.ring_meta;
      // Next state on mode select
      unique case (t_r.st)
         sbstap_pkg::ST_RESET: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_RESET;
            end else begin
               t_nxt.st = sbstap_pkg::ST_IDLE;
            end
         end
         sbstap_pkg::ST_IDLE: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_SEL_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_IDLE;
            end
         end
         sbstap_pkg::ST_SEL_DR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_SEL_IR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_CAP_DR;
            end
         end
         sbstap_pkg::ST_CAP_DR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_EX1_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_SHIFT_DR;
            end
         end
         sbstap_pkg::ST_SHIFT_DR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_EX1_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_SHIFT_DR;
            end
         end
         sbstap_pkg::ST_EX1_DR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_UPD_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_PAUSE_DR;
            end
         end
         sbstap_pkg::ST_PAUSE_DR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_EX2_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_PAUSE_DR;
            end
         end
         sbstap_pkg::ST_EX2_DR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_UPD_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_SHIFT_DR;
            end
         end
         sbstap_pkg::ST_UPD_DR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_SEL_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_IDLE;
            end
         end
         sbstap_pkg::ST_SEL_IR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_RESET;
            end else begin
               t_nxt.st = sbstap_pkg::ST_CAP_IR;
            end
         end
         sbstap_pkg::ST_CAP_IR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_EX1_IR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_SHIFT_IR;
            end
         end
         sbstap_pkg::ST_SHIFT_IR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_EX1_IR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_SHIFT_IR;
            end
         end
         sbstap_pkg::ST_EX1_IR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_UPD_IR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_PAUSE_IR;
            end
         end
         sbstap_pkg::ST_PAUSE_IR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_EX2_IR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_PAUSE_IR;
            end
         end
         sbstap_pkg::ST_EX2_IR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_UPD_IR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_SHIFT_IR;
            end
         end
         sbstap_pkg::ST_UPD_IR: begin
            if (tms) begin
               t_nxt.st = sbstap_pkg::ST_SEL_DR;
            end else begin
               t_nxt.st = sbstap_pkg::ST_IDLE;
            end
         end
      endcase
      // Instruction path
      unique case (t_r.st)
         sbstap_pkg::ST_CAP_IR: begin
            t_nxt.ir_sh = `SBSTAP_IR_CAPTURE;
         end
         sbstap_pkg::ST_SHIFT_IR: begin
            t_nxt.ir_sh = {tdi, t_r.ir_sh[`SBSTAP_IR_W-1:1]};
         end
         sbstap_pkg::ST_UPD_IR: begin
            t_nxt.ir = sbstap_pkg::sbstap_instr_t'(t_r.ir_sh);
         end
         default: begin
         end
      endcase
      // Data path, one register per instruction
      unique case (t_r.ir)
         sbstap_pkg::OP_EXTEST, sbstap_pkg::OP_SAMPLE,
         sbstap_pkg::OP_SAMPLE_Z: begin
            ring_cap = 1'b1;
         end
         default: begin
         end
      endcase
      if (t_r.st == sbstap_pkg::ST_CAP_DR) begin
         if (ring_cap) begin
            t_nxt.bsr_sh = t_r.ring_sync;
         end else if (t_r.ir == sbstap_pkg::OP_IDCODE) begin
            t_nxt.idr = id_val;
         end else begin
            t_nxt.bypass = `SBSTAP_BYPASS_CAPTURE;
         end
      end
      if (t_r.st == sbstap_pkg::ST_SHIFT_DR) begin
         if (ring_cap) begin
            t_nxt.bsr_sh = {tdi, t_r.bsr_sh[`SBSTAP_BSR_W-1:1]};
         end else if (t_r.ir == sbstap_pkg::OP_IDCODE) begin
            t_nxt.idr = {tdi, t_r.idr[`SBSTAP_ID_W-1:1]};
         end else begin
            t_nxt.bypass = tdi;
         end
      end
      if (t_r.st == sbstap_pkg::ST_UPD_DR && ring_cap) begin
         t_nxt.bsr_upd = t_r.bsr_sh;
      end
      // Controller reset, by power-up or by mode select
      if (t_r.rst_sync || t_r.st == sbstap_pkg::ST_RESET) begin
         if (t_r.rst_sync) begin
            t_nxt.st = sbstap_pkg::ST_RESET;
         end
         t_nxt.ir = sbstap_pkg::OP_IDCODE;
         // Preset output-enable cell
         t_nxt.bsr_upd[`SBSTAP_OE_CELL] = 1'b1;
      end
   end

   // Rising edge samples pins
   always_ff @(posedge tck) begin
      t_r <= t_nxt;
   end

   // ===============================================================
   // Falling edge output stage
   always_comb begin
      o_nxt.tdo = 1'b0;
      o_nxt.tdo_oe_n = 1'b1;
      if (t_r.st == sbstap_pkg::ST_SHIFT_IR) begin
         o_nxt.tdo = t_r.ir_sh[0];
         o_nxt.tdo_oe_n = 1'b0;
      end else if (t_r.st == sbstap_pkg::ST_SHIFT_DR) begin
         o_nxt.tdo_oe_n = 1'b0;
         if (ring_cap) begin
            o_nxt.tdo = t_r.bsr_sh[0];
         end else if (t_r.ir == sbstap_pkg::OP_IDCODE) begin
            o_nxt.tdo = t_r.idr[0];
         end else begin
            o_nxt.tdo = t_r.bypass;
         end
      end
      // Held off during power-up reset
      if (t_r.rst_sync) begin
         o_nxt.tdo_oe_n = 1'b1;
      end
   end

   always_ff @(negedge tck) begin
      o_r <= o_nxt;
   end

   assign tdo = o_r.tdo;
   assign tdo_oe_n = o_r.tdo_oe_n;

   // ===============================================================
   // Core clock domain
   sbstap_pkg::sbstap_core_t c_r;
   sbstap_pkg::sbstap_core_t c_nxt;

   always_comb begin
      c_nxt = c_r;
      c_nxt.ir_meta = t_r.ir;
      c_nxt.ir_sync = c_r.ir_meta;
      c_nxt.upd_meta = t_r.bsr_upd;
      c_nxt.upd_sync = c_r.upd_meta;
      c_nxt.extest = (c_r.ir_sync == `SBSTAP_OP_EXTEST);
      c_nxt.ring_drive = c_r.upd_sync;
      c_nxt.q_hiz = (c_r.ir_sync == `SBSTAP_OP_SAMPLE_Z) ||
         (c_nxt.extest && !c_r.upd_sync[`SBSTAP_OE_CELL]);
      if (srst) begin
         c_nxt.ir_meta = `SBSTAP_OP_IDCODE;
         c_nxt.ir_sync = `SBSTAP_OP_IDCODE;
         c_nxt.upd_meta = '0;
         c_nxt.upd_sync = '0;
         c_nxt.upd_meta[`SBSTAP_OE_CELL] = 1'b1;
         c_nxt.upd_sync[`SBSTAP_OE_CELL] = 1'b1;
         c_nxt.extest = 1'b0;
         c_nxt.q_hiz = 1'b0;
         c_nxt.ring_drive = '0;
      end
   end

   always_ff @(posedge clk) begin
      c_r <= c_nxt;
   end

   assign ring_drive = c_r.ring_drive;
   assign extest_active = c_r.extest;
   assign q_bus_hiz = c_r.q_hiz;

endmodule

// ==== rtl/sbstap_cfg.svh ====
`ifndef SBSTAP_CFG_SVH
`define SBSTAP_CFG_SVH

// ==================================================================
// Scan register sizes
`define SBSTAP_IR_W 3
`define SBSTAP_ID_W 32
`define SBSTAP_BSR_W 90
`define SBSTAP_OE_CELL 89

// ==================================================================
// Instruction encodings
`define SBSTAP_OP_EXTEST 3'h0
`define SBSTAP_OP_IDCODE 3'h1
`define SBSTAP_OP_SAMPLE_Z 3'h2
`define SBSTAP_OP_RSVD0 3'h3
`define SBSTAP_OP_SAMPLE 3'h4
`define SBSTAP_OP_RSVD1 3'h5
`define SBSTAP_OP_RSVD2 3'h6
`define SBSTAP_OP_BYPASS 3'h7

// ==================================================================
// Capture and reset values
`define SBSTAP_IR_CAPTURE 3'h1
`define SBSTAP_BYPASS_CAPTURE 1'h0
// Identification value is arbitrary
`define SBSTAP_IDCODE_VAL 32'h0a5c_0001
`define SBSTAP_TLR_ONES 3'h4

`endif

// ==== rtl/sbstap_pkg.sv ====
`include "sbstap_cfg.svh"

package sbstap_pkg;

   // ===============================================================
   // Controller states
   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_IDLE = 4'h1,
      ST_SEL_DR = 4'h3,
      ST_CAP_DR = 4'h2,
      ST_SHIFT_DR = 4'h6,
      ST_EX1_DR = 4'h7,
      ST_PAUSE_DR = 4'h5,
      ST_EX2_DR = 4'h4,
      ST_UPD_DR = 4'hc,
      ST_SEL_IR = 4'hd,
      ST_CAP_IR = 4'hf,
      ST_SHIFT_IR = 4'he,
      ST_EX1_IR = 4'ha,
      ST_PAUSE_IR = 4'hb,
      ST_EX2_IR = 4'h9,
      ST_UPD_IR = 4'h8
   } sbstap_state_t;

   // ===============================================================
   // Instructions
   typedef enum logic [`SBSTAP_IR_W-1:0] {
      OP_EXTEST = `SBSTAP_OP_EXTEST,
      OP_IDCODE = `SBSTAP_OP_IDCODE,
      OP_SAMPLE_Z = `SBSTAP_OP_SAMPLE_Z,
      OP_RSVD0 = `SBSTAP_OP_RSVD0,
      OP_SAMPLE = `SBSTAP_OP_SAMPLE,
      OP_RSVD1 = `SBSTAP_OP_RSVD1,
      OP_RSVD2 = `SBSTAP_OP_RSVD2,
      OP_BYPASS = `SBSTAP_OP_BYPASS
   } sbstap_instr_t;

   typedef logic [`SBSTAP_BSR_W-1:0] sbstap_ring_t;

   // ===============================================================
   // Test clock domain state
   typedef struct packed {
      logic rst_meta;
      logic rst_sync;
      sbstap_ring_t ring_meta;
      sbstap_ring_t ring_sync;
      sbstap_state_t st;
      logic [`SBSTAP_IR_W-1:0] ir_sh;
      sbstap_instr_t ir;
      logic bypass;
      logic [`SBSTAP_ID_W-1:0] idr;
      sbstap_ring_t bsr_sh;
      sbstap_ring_t bsr_upd;
   } sbstap_tck_t;

   // ===============================================================
   // Falling edge output stage
   typedef struct packed {
      logic tdo;
      logic tdo_oe_n;
   } sbstap_out_t;

   // ===============================================================
   // Core clock domain state
   typedef struct packed {
      logic [`SBSTAP_IR_W-1:0] ir_meta;
      logic [`SBSTAP_IR_W-1:0] ir_sync;
      sbstap_ring_t upd_meta;
      sbstap_ring_t upd_sync;
      logic extest;
      logic q_hiz;
      sbstap_ring_t ring_drive;
   } sbstap_core_t;

endpackage

// ==== tb/sbstap_top_sva.sv ====
`timescale 1ns/1ps
// ====
// Port checker
module sbstap_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   input wire sbstap_pkg::sbstap_ring_t ring_in,
   input wire sbstap_pkg::sbstap_ring_t ring_drive,
   input wire logic extest_active,
   input wire logic q_bus_hiz
);
   logic [2:0] low_r;
   // Core cycles with tck low
   always_ff @(posedge clk) begin
      if (srst || tck) begin
         low_r <= 3'h0;
      end else if (low_r != 3'h7) begin
         low_r <= low_r + 3'h1;
      end
   end
   sequence five_high;
      tms [*5];
   endsequence
   sequence two_low;
      !$past(tms, 2) && !$past(tms);
   endsequence
   tdo_edge_a: assert property (@(posedge clk) disable iff (srst)
      $changed(tdo) |-> !tck) else $error("tdo moved, tck high");
   oe_edge_a: assert property (@(posedge clk) disable iff (srst)
      $changed(tdo_oe_n) |-> !tck) else $error("oe moved, tck high");
   quiet_low_a: assert property (@(posedge clk) disable iff (srst)
      tdo_oe_n |-> !tdo) else $error("tdo high while off");
   tms_reset_a: assert property (@(posedge tck) disable iff (srst)
      five_high |=> tdo_oe_n) else $error("no reset after five");
   shift_entry_a: assert property (@(posedge tck) disable iff (srst)
      $fell(tdo_oe_n) |-> two_low) else $error("bad shift entry");
   shift_exit_a: assert property (@(posedge tck) disable iff (srst)
      !tdo_oe_n |=> tdo_oe_n == $past(tms)) else $error("bad shift");
   oe_cell_a: assert property (@(posedge clk) disable iff (srst)
      extest_active |-> q_bus_hiz == !ring_drive[89])
      else $error("q bus not from cell");
   core_reset_a: assert property (@(posedge clk)
      srst |=> !extest_active && !q_bus_hiz && ring_drive == '0)
      else $error("core outputs not reset");
   idle_stable_a: assert property (@(posedge clk) disable iff (srst)
      low_r >= 3'h5 |-> $stable(ring_drive) && $stable(q_bus_hiz)
      && $stable(extest_active)) else $error("core moved, tck idle");
endmodule

bind sbstap_top sbstap_chk sbstap_chk_inst (.clk, .srst, .tck, .tms,
   .tdi, .tdo, .tdo_oe_n, .ring_in, .ring_drive, .extest_active,
   .q_bus_hiz);

// ==== tb/sbstap_host.sv ====
`timescale 1ns/1ps
// ====
// Board test controller
module sbstap_host (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   logic last_r;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      last_r = 1'b0;
   end
   // One period, tck parked low after
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #40;
      o = tdo_oe_n ? ~last_r : tdo;
      last_r = o;
      tck = 1'b1;
      #40;
      tck = 1'b0;
   endtask
   task automatic reset5();
      logic o;
      repeat (5) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask
   // Scan from idle back to idle
   task automatic scan(input logic ir, input int n,
      input sbstap_pkg::sbstap_ring_t din,
      output sbstap_pkg::sbstap_ring_t dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b1, o);
      if (ir) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      step(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask
endmodule

// ==== tb/test_sram_boundary_scan_tap.sv ====
`timescale 1ns/1ps
`include "sbstap_cfg.svh"
`define CHK(nm, e, s) \
   begin \
      n_tests++; \
      if ((s) !== (e)) begin \
         $display("MISMATCH %s exp %h seen %h", nm, e, s); \
         mismatches++; \
      end \
   end
// ====
// Bench top
module test_sram_boundary_scan_tap;
   logic clk, srst, tck, tms, tdi, tdo, tdo_oe_n;
   logic extest_active, q_bus_hiz;
   sbstap_pkg::sbstap_ring_t ring_in, ring_drive;
   int mismatches = 0;
   int n_tests = 0;
   sbstap_top sbstap_top_inst (.clk(clk), .srst(srst), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .ring_in(ring_in), .ring_drive(ring_drive),
      .extest_active(extest_active), .q_bus_hiz(q_bus_hiz));
   sbstap_host sbstap_host_inst (.tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic t_idcode();
      sbstap_pkg::sbstap_ring_t d;
      `CHK("oe_n", 1'b1, tdo_oe_n);
      sbstap_host_inst.scan(1'b0, 32, '1, d);
      `CHK("idcode", `SBSTAP_IDCODE_VAL, d[31:0]);
   endtask
   task automatic t_bypass();
      sbstap_pkg::sbstap_ring_t d;
      logic [3:0] din;
      for (int k = 0; k < 4; k++) begin
         din = 4'hb ^ 4'(k);
         sbstap_host_inst.scan(1'b1, 3, 90'(`SBSTAP_OP_BYPASS), d);
         `CHK("ir_cap", `SBSTAP_IR_CAPTURE, d[2:0]);
         sbstap_host_inst.scan(1'b0, 4, 90'(din), d);
         `CHK("bypass", {din[2:0], 1'b0}, d[3:0]);
      end
   endtask
   task automatic t_ring();
      sbstap_pkg::sbstap_ring_t a, b, d;
      a = {45{2'b10}};
      b = {2'b01, {44{2'b10}}};
      @(posedge clk) #1 ring_in = a;
      sbstap_host_inst.scan(1'b1, 3, 90'(`SBSTAP_OP_SAMPLE), d);
      sbstap_host_inst.scan(1'b0, 90, b, d);
      `CHK("sample", a, d);
      sbstap_host_inst.scan(1'b1, 3, 90'(`SBSTAP_OP_EXTEST), d);
      `CHK("drive", b, ring_drive);
      `CHK("extest", 1'b1, extest_active);
      `CHK("q_off", 1'b1, q_bus_hiz);
      @(posedge clk) #1 ring_in = ~a;
      sbstap_host_inst.scan(1'b0, 90, b, d);
      `CHK("ext_cap", ~a, d);
      sbstap_host_inst.scan(1'b1, 3, 90'(`SBSTAP_OP_SAMPLE_Z), d);
      `CHK("z_ext", 1'b0, extest_active);
      `CHK("z_q_off", 1'b1, q_bus_hiz);
      sbstap_host_inst.reset5();
      `CHK("rst_q", 1'b0, q_bus_hiz);
      `CHK("oe_cell", 1'b1, ring_drive[89]);
      t_idcode();
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      srst = 1'b1;
      ring_in = '0;
      repeat (20) @(posedge clk);
      sbstap_host_inst.reset5();
      @(posedge clk) #1 srst = 1'b0;
      sbstap_host_inst.reset5();
      t_idcode();
      t_bypass();
      t_ring();
      print_verdict();
   end
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
endmodule
